// *** shared/gdmc_defines.svh ***
// gdmc_defines.svh: offsets, field positions, reset values and timing counts
// assumes a single 100 MHz core clock
`ifndef GDMC_DEFINES_SVH
`define GDMC_DEFINES_SVH

`define GDMC_ADDR_W           4
`define GDMC_DATA_W           8

`define GDMC_OFS_OC_THRESH    4'ha
`define GDMC_OFS_DIAG         4'hb
`define GDMC_OFS_SUPPLY_MON   4'hc
`define GDMC_OFS_AMP          4'hd

`define GDMC_RST_OC_THRESH    8'hdd
`define GDMC_RST_DIAG         8'h00
`define GDMC_RST_SUPPLY_MON   8'h14
`define GDMC_RST_AMP          8'h01

// overcurrent threshold fields
`define GDMC_HS_OC_MSB        7
`define GDMC_HS_OC_LSB        4
`define GDMC_LS_OC_MSB        3
`define GDMC_LS_OC_LSB        0

// offline diagnostic fields
`define GDMC_DIAG_EN_BIT      4
`define GDMC_DIAG_PU_BIT      3
`define GDMC_DIAG_PD_BIT      2

// supply monitor fields
`define GDMC_SUV_RESP_BIT     7
`define GDMC_SOV_RESP_MSB     6
`define GDMC_SOV_RESP_LSB     5
`define GDMC_SOV_DG_MSB       4
`define GDMC_SOV_DG_LSB       3
`define GDMC_SOV_THR_BIT      2
`define GDMC_PUV_RESP_BIT     1
`define GDMC_PUV_THR_BIT      0

// amplifier fields
`define GDMC_AMP_SH_BIT       7
`define GDMC_AMP_BLKSRC_BIT   6
`define GDMC_AMP_BLK_MSB      5
`define GDMC_AMP_BLK_LSB      3
`define GDMC_AMP_DIV_BIT      2
`define GDMC_AMP_GAIN_MSB     1
`define GDMC_AMP_GAIN_LSB     0

// timing
`define GDMC_CLK_MHZ          100
`define GDMC_SOV_DG_BASE_US   1
`define GDMC_SOV_DG_BASE_CYC  (`GDMC_SOV_DG_BASE_US * `GDMC_CLK_MHZ)
`define GDMC_UV_DG_CYC        1
`define GDMC_DG_W             10
`define GDMC_NUM_MON          3

`endif

// *** shared/gdmc_pkg.sv ***
// gdmc_pkg: types of the gate driver configuration bank
// assumes gdmc_defines.svh for numbers
package gdmc_pkg;

	typedef enum logic [1:0] {
		OV_RESP_LATCH = 2'b00,
		OV_RESP_AUTO  = 2'b01,
		OV_RESP_WARN  = 2'b10,
		OV_RESP_OFF   = 2'b11
	} gdmc_ov_resp_type;

	typedef enum logic [1:0] {
		MON_SUPPLY_UV = 2'd0,
		MON_SUPPLY_OV = 2'd1,
		MON_PUMP_UV   = 2'd2
	} gdmc_mon_id_type;

endpackage : gdmc_pkg

// *** shared/gdmc_mon_if.sv ***
// gdmc_mon_if: configuration and result of one fault monitor
// assumes the bank drives the cfg side and one monitor the mon side
`timescale 1ns/1ns
`include "gdmc_defines.svh"
interface gdmc_mon_if;
	logic                   condition;
	logic                   enable;
	logic                   latched;
	logic                   warn_only;
	logic [`GDMC_DG_W-1:0]  dg_cycles;
	logic                   clear;
	logic                   fault;
	logic                   warning;

	modport cfg (
		output condition,
		output enable,
		output latched,
		output warn_only,
		output dg_cycles,
		output clear,
		input  fault,
		input  warning
	);

	modport mon (
		input  condition,
		input  enable,
		input  latched,
		input  warn_only,
		input  dg_cycles,
		input  clear,
		output fault,
		output warning
	);
endinterface : gdmc_mon_if

// *** hw/gdmc_monitor.sv ***
// gdmc_monitor: deglitch and latched or auto-recovery fault of one monitor
// assumes condition is synchronous to i_core_clk
`timescale 1ns/1ns
`include "gdmc_defines.svh"
module gdmc_monitor
	import gdmc_pkg::*;
(
	input  wire logic i_core_clk,
	input  wire logic i_sys_rst,
	gdmc_mon_if.mon   mon
);
	logic [`GDMC_DG_W-1:0] cnt_ff;
	logic [`GDMC_DG_W-1:0] nxt_cnt;
	logic                  fault_ff;
	logic                  nxt_fault;
	logic                  warn_ff;
	logic                  nxt_warn;
	wire                   active;
	wire                   qualified;

	assign active    = mon.enable & mon.condition;
	assign qualified = active & (cnt_ff >= mon.dg_cycles);
	assign nxt_cnt   = !active ? '0 :
	                   (cnt_ff >= mon.dg_cycles) ? cnt_ff : cnt_ff + 1'b1;
	// latched holds past the condition until cleared; set wins over clear
	assign nxt_fault = !mon.enable || mon.warn_only ? 1'b0 :
	                   qualified ? 1'b1 :
	                   mon.latched ? (fault_ff & ~mon.clear) : 1'b0;
	assign nxt_warn  = mon.warn_only & qualified;

	always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			cnt_ff   <= '0;
			fault_ff <= 1'b0;
			warn_ff  <= 1'b0;
		end else begin
			cnt_ff   <= nxt_cnt;
			fault_ff <= nxt_fault;
			warn_ff  <= nxt_warn;
		end
	end

	assign mon.fault   = fault_ff;
	assign mon.warning = warn_ff;
endmodule : gdmc_monitor

// *** hw/gdmc_regs.sv ***
// gdmc_regs: four configuration registers of a half-bridge gate driver
// assumes a serial front end presents decoded single-cycle reads and writes
`timescale 1ns/1ns
`include "gdmc_defines.svh"
module gdmc_regs
	import gdmc_pkg::*;
(
	input  wire logic                    i_core_clk,
	input  wire logic                    i_sys_rst,
	input  wire logic [`GDMC_ADDR_W-1:0] i_reg_addr,
	input  wire logic [`GDMC_DATA_W-1:0] i_reg_wdata,
	input  wire logic                    i_reg_wr,
	input  wire logic                    i_reg_rd,
	output logic      [`GDMC_DATA_W-1:0] o_reg_rdata,
	output logic                         o_reg_rvalid,
	output logic                         o_reg_hit,
	input  wire logic                    i_fault_clear,
	input  wire logic                    i_supply_uv_detect,
	input  wire logic                    i_supply_ov_detect,
	input  wire logic                    i_pump_uv_detect,
	output logic      [3:0]              o_high_side_overcurrent_threshold,
	output logic      [3:0]              o_low_side_overcurrent_threshold,
	output logic                         o_offline_diagnostic_enable,
	output logic                         o_vds_realtime_monitor,
	output logic                         o_bridge1_pullup_source_enable,
	output logic                         o_bridge1_pulldown_source_enable,
	output logic                         o_supply_undervoltage_response,
	output logic      [1:0]              o_supply_overvoltage_response,
	output logic      [1:0]              o_supply_overvoltage_deglitch,
	output logic                         o_supply_overvoltage_threshold,
	output logic                         o_pump_undervoltage_response,
	output logic                         o_pump_undervoltage_threshold,
	output logic                         o_amp_sample_hold_enable,
	output logic                         o_amp_blanking_source_select,
	output logic      [2:0]              o_amp_blanking_time,
	output logic                         o_amp_blanking_enable,
	output logic                         o_amp_reference_divider,
	output logic      [1:0]              o_amp_gain_select,
	output logic      [6:0]              o_amp_gain_value,
	output logic                         o_supply_uv_fault,
	output logic                         o_supply_ov_fault,
	output logic                         o_supply_ov_warning,
	output logic                         o_pump_uv_fault
);
	// register storage
	logic [`GDMC_DATA_W-1:0] oc_thresh_ff;
	logic [`GDMC_DATA_W-1:0] diag_ff;
	logic [`GDMC_DATA_W-1:0] supply_mon_ff;
	logic [`GDMC_DATA_W-1:0] amp_ff;
	logic [`GDMC_DATA_W-1:0] nxt_oc_thresh;
	logic [`GDMC_DATA_W-1:0] nxt_diag;
	logic [`GDMC_DATA_W-1:0] nxt_supply_mon;
	logic [`GDMC_DATA_W-1:0] nxt_amp;
	logic [`GDMC_DATA_W-1:0] rdata_ff;
	logic [`GDMC_DATA_W-1:0] nxt_rdata;
	logic                    rvalid_ff;
	logic                    hit_ff;
	logic                    pullup_ff;
	logic                    pulldown_ff;
	logic                    nxt_pullup;
	logic                    nxt_pulldown;
	logic [6:0]              gain_ff;
	logic [6:0]              nxt_gain;

	// address decode
	wire sel_oc_thresh  = (i_reg_addr == `GDMC_OFS_OC_THRESH);
	wire sel_diag       = (i_reg_addr == `GDMC_OFS_DIAG);
	wire sel_supply_mon = (i_reg_addr == `GDMC_OFS_SUPPLY_MON);
	wire sel_amp        = (i_reg_addr == `GDMC_OFS_AMP);
	wire sel_any        = sel_oc_thresh | sel_diag | sel_supply_mon | sel_amp;

	// full-byte writes; reserved diagnostic bits are stored as written
	assign nxt_oc_thresh  = (i_reg_wr & sel_oc_thresh)  ? i_reg_wdata : oc_thresh_ff;
	assign nxt_diag       = (i_reg_wr & sel_diag)       ? i_reg_wdata : diag_ff;
	assign nxt_supply_mon = (i_reg_wr & sel_supply_mon) ? i_reg_wdata : supply_mon_ff;
	assign nxt_amp        = (i_reg_wr & sel_amp)        ? i_reg_wdata : amp_ff;

	// read mux, unmapped reads return zero
	assign nxt_rdata = sel_oc_thresh  ? oc_thresh_ff  :
	                   sel_diag       ? diag_ff       :
	                   sel_supply_mon ? supply_mon_ff :
	                   sel_amp        ? amp_ff        : 8'h00;

	// sources act only together with the diagnostic enable
	assign nxt_pullup   = nxt_diag[`GDMC_DIAG_PU_BIT] & nxt_diag[`GDMC_DIAG_EN_BIT];
	assign nxt_pulldown = nxt_diag[`GDMC_DIAG_PD_BIT] & nxt_diag[`GDMC_DIAG_EN_BIT];

	// gain decode
	wire [1:0] nxt_gain_code = nxt_amp[`GDMC_AMP_GAIN_MSB:`GDMC_AMP_GAIN_LSB];
	assign nxt_gain = (nxt_gain_code == 2'b00) ? 7'd10 :
	                  (nxt_gain_code == 2'b01) ? 7'd20 :
	                  (nxt_gain_code == 2'b10) ? 7'd40 : 7'd80;

	always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			oc_thresh_ff  <= `GDMC_RST_OC_THRESH;
			diag_ff       <= `GDMC_RST_DIAG;
			supply_mon_ff <= `GDMC_RST_SUPPLY_MON;
			amp_ff        <= `GDMC_RST_AMP;
			pullup_ff     <= 1'b0;
			pulldown_ff   <= 1'b0;
			gain_ff       <= 7'd20;
		end else begin
			oc_thresh_ff  <= nxt_oc_thresh;
			diag_ff       <= nxt_diag;
			supply_mon_ff <= nxt_supply_mon;
			amp_ff        <= nxt_amp;
			pullup_ff     <= nxt_pullup;
			pulldown_ff   <= nxt_pulldown;
			gain_ff       <= nxt_gain;
		end
	end

	always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			rdata_ff  <= 8'h00;
			rvalid_ff <= 1'b0;
			hit_ff    <= 1'b0;
		end else begin
			rdata_ff  <= i_reg_rd ? nxt_rdata : rdata_ff;
			rvalid_ff <= i_reg_rd;
			hit_ff    <= (i_reg_rd | i_reg_wr) & sel_any;
		end
	end

	assign o_reg_rdata  = rdata_ff;
	assign o_reg_rvalid = rvalid_ff;
	assign o_reg_hit    = hit_ff;

	// threshold codes, sixteen ascending steps each
	assign o_high_side_overcurrent_threshold = oc_thresh_ff[`GDMC_HS_OC_MSB:`GDMC_HS_OC_LSB];
	assign o_low_side_overcurrent_threshold  = oc_thresh_ff[`GDMC_LS_OC_MSB:`GDMC_LS_OC_LSB];

	// offline diagnostics
	assign o_offline_diagnostic_enable      = diag_ff[`GDMC_DIAG_EN_BIT];
	assign o_vds_realtime_monitor           = diag_ff[`GDMC_DIAG_EN_BIT];
	assign o_bridge1_pullup_source_enable   = pullup_ff;
	assign o_bridge1_pulldown_source_enable = pulldown_ff;

	// supply and pump monitor configuration
	assign o_supply_undervoltage_response = supply_mon_ff[`GDMC_SUV_RESP_BIT];
	assign o_supply_overvoltage_response  =
		supply_mon_ff[`GDMC_SOV_RESP_MSB:`GDMC_SOV_RESP_LSB];
	assign o_supply_overvoltage_deglitch  =
		supply_mon_ff[`GDMC_SOV_DG_MSB:`GDMC_SOV_DG_LSB];
	assign o_supply_overvoltage_threshold = supply_mon_ff[`GDMC_SOV_THR_BIT];
	assign o_pump_undervoltage_response   = supply_mon_ff[`GDMC_PUV_RESP_BIT];
	assign o_pump_undervoltage_threshold  = supply_mon_ff[`GDMC_PUV_THR_BIT];

	// amplifier configuration
	assign o_amp_sample_hold_enable     = amp_ff[`GDMC_AMP_SH_BIT];
	assign o_amp_blanking_source_select = amp_ff[`GDMC_AMP_BLKSRC_BIT];
	assign o_amp_blanking_time          = amp_ff[`GDMC_AMP_BLK_MSB:`GDMC_AMP_BLK_LSB];
	assign o_amp_blanking_enable        = |amp_ff[`GDMC_AMP_BLK_MSB:`GDMC_AMP_BLK_LSB];
	assign o_amp_reference_divider      = amp_ff[`GDMC_AMP_DIV_BIT];
	assign o_amp_gain_select            = amp_ff[`GDMC_AMP_GAIN_MSB:`GDMC_AMP_GAIN_LSB];
	assign o_amp_gain_value             = gain_ff;

	// monitor configuration per channel
	gdmc_ov_resp_type      ov_resp;
	wire [`GDMC_DG_W-1:0]  ov_dg_cycles;
	logic [`GDMC_NUM_MON-1:0] mon_cond;
	logic [`GDMC_NUM_MON-1:0] mon_en;
	logic [`GDMC_NUM_MON-1:0] mon_latch;
	logic [`GDMC_NUM_MON-1:0] mon_warn;
	logic [`GDMC_NUM_MON-1:0] mon_fault;
	logic [`GDMC_NUM_MON-1:0] mon_warning;
	logic [`GDMC_DG_W-1:0]    mon_dg [`GDMC_NUM_MON];

	assign ov_resp = gdmc_ov_resp_type'(o_supply_overvoltage_response);
	// 1 us doubled per code step
	assign ov_dg_cycles = `GDMC_DG_W'(`GDMC_SOV_DG_BASE_CYC) << o_supply_overvoltage_deglitch;

	assign mon_cond[MON_SUPPLY_UV]  = i_supply_uv_detect;
	assign mon_cond[MON_SUPPLY_OV]  = i_supply_ov_detect;
	assign mon_cond[MON_PUMP_UV]    = i_pump_uv_detect;
	assign mon_en[MON_SUPPLY_UV]    = 1'b1;
	assign mon_en[MON_SUPPLY_OV]    = (ov_resp != OV_RESP_OFF);
	assign mon_en[MON_PUMP_UV]      = 1'b1;
	assign mon_latch[MON_SUPPLY_UV] = ~o_supply_undervoltage_response;
	assign mon_latch[MON_SUPPLY_OV] = (ov_resp == OV_RESP_LATCH);
	assign mon_latch[MON_PUMP_UV]   = ~o_pump_undervoltage_response;
	assign mon_warn[MON_SUPPLY_UV]  = 1'b0;
	assign mon_warn[MON_SUPPLY_OV]  = (ov_resp == OV_RESP_WARN);
	assign mon_warn[MON_PUMP_UV]    = 1'b0;
	assign mon_dg[MON_SUPPLY_UV]    = `GDMC_DG_W'(`GDMC_UV_DG_CYC);
	assign mon_dg[MON_SUPPLY_OV]    = ov_dg_cycles;
	assign mon_dg[MON_PUMP_UV]      = `GDMC_DG_W'(`GDMC_UV_DG_CYC);

	gdmc_mon_if mon_bus [`GDMC_NUM_MON] ();

	genvar gi;
	generate
		for (gi = 0; gi < `GDMC_NUM_MON; gi++) begin : g_mon
			assign mon_bus[gi].condition = mon_cond[gi];
			assign mon_bus[gi].enable    = mon_en[gi];
			assign mon_bus[gi].latched   = mon_latch[gi];
			assign mon_bus[gi].warn_only = mon_warn[gi];
			assign mon_bus[gi].dg_cycles = mon_dg[gi];
			assign mon_bus[gi].clear     = i_fault_clear;
			assign mon_fault[gi]         = mon_bus[gi].fault;
			assign mon_warning[gi]       = mon_bus[gi].warning;

			gdmc_monitor u_monitor (
				.i_core_clk (i_core_clk),
				.i_sys_rst  (i_sys_rst),
				.mon        (mon_bus[gi])
			);
		end
	endgenerate

	assign o_supply_uv_fault   = mon_fault[MON_SUPPLY_UV];
	assign o_supply_ov_fault   = mon_fault[MON_SUPPLY_OV];
	assign o_supply_ov_warning = mon_warning[MON_SUPPLY_OV];
	assign o_pump_uv_fault     = mon_fault[MON_PUMP_UV];
endmodule : gdmc_regs

// *** verification/gdmc_regs_chk.sv ***
// gdmc_regs_chk: port assertions for the configuration bank
// assumes bind onto gdmc_regs, one core clock
`timescale 1ns/1ns
`include "gdmc_defines.svh"
module gdmc_regs_chk (
	input wire logic                    i_core_clk,
	input wire logic                    i_sys_rst,
	input wire logic [`GDMC_ADDR_W-1:0] i_reg_addr,
	input wire logic [`GDMC_DATA_W-1:0] i_reg_wdata,
	input wire logic                    i_reg_wr,
	input wire logic                    i_reg_rd,
	input wire logic                    o_reg_rvalid,
	input wire logic                    i_fault_clear,
	input wire logic                    i_supply_uv_detect,
	input wire logic                    i_pump_uv_detect,
	input wire logic [3:0]              o_high_side_overcurrent_threshold,
	input wire logic [3:0]              o_low_side_overcurrent_threshold,
	input wire logic                    o_offline_diagnostic_enable,
	input wire logic                    o_bridge1_pullup_source_enable,
	input wire logic                    o_bridge1_pulldown_source_enable,
	input wire logic                    o_supply_undervoltage_response,
	input wire logic [1:0]              o_supply_overvoltage_response,
	input wire logic                    o_pump_undervoltage_response,
	input wire logic [1:0]              o_amp_gain_select,
	input wire logic [6:0]              o_amp_gain_value,
	input wire logic                    o_supply_uv_fault,
	input wire logic                    o_supply_ov_fault,
	input wire logic                    o_supply_ov_warning,
	input wire logic                    o_pump_uv_fault
);
	default clocking cb @(posedge i_core_clk); endclocking
	default disable iff (i_sys_rst);
	wire logic oc_wr = i_reg_wr && (i_reg_addr == `GDMC_OFS_OC_THRESH);
	wire logic mon_wr = i_reg_wr && (i_reg_addr == `GDMC_OFS_SUPPLY_MON);

	chk_rd_answer: assert property (i_reg_rd |=> o_reg_rvalid)
		else $error("read strobe not answered");
	chk_hs_write: assert property (oc_wr |=>
		o_high_side_overcurrent_threshold == $past(i_reg_wdata[7:4]))
		else $error("high side threshold not written");
	chk_ls_write: assert property (oc_wr |=>
		o_low_side_overcurrent_threshold == $past(i_reg_wdata[3:0]))
		else $error("low side threshold not written");
	chk_pullup_gate: assert property (o_bridge1_pullup_source_enable |->
		o_offline_diagnostic_enable) else $error("pullup source without enable");
	chk_pulldown_gate: assert property (o_bridge1_pulldown_source_enable |->
		o_offline_diagnostic_enable) else $error("pulldown source without enable");
	chk_gain_decode: assert property (
		o_amp_gain_value == (7'h0a << o_amp_gain_select)) else $error("gain decode wrong");
	chk_latch_hold: assert property (o_supply_uv_fault && !o_supply_undervoltage_response
		&& !i_fault_clear && !mon_wr |=> o_supply_uv_fault) else $error("latched fault lost");
	chk_ov_disabled: assert property (o_supply_overvoltage_response == 2'b11 [*2]
		|-> !o_supply_ov_fault && !o_supply_ov_warning) else $error("disabled monitor active");
	chk_auto_release: assert property ((o_pump_undervoltage_response
		&& !i_pump_uv_detect) [*2] |=> !o_pump_uv_fault) else $error("auto fault kept");
	chk_uv_deglitch: assert property (i_supply_uv_detect [*3] |=> o_supply_uv_fault)
		else $error("undervoltage fault not raised");

	cover property (o_bridge1_pullup_source_enable);
	cover property (o_supply_ov_warning);
	cover property (o_supply_uv_fault && i_fault_clear);
endmodule : gdmc_regs_chk

bind gdmc_regs gdmc_regs_chk i_gdmc_regs_chk (.i_core_clk(i_core_clk), .i_sys_rst(i_sys_rst),
	.i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata), .i_reg_wr(i_reg_wr),
	.i_reg_rd(i_reg_rd), .o_reg_rvalid(o_reg_rvalid), .i_fault_clear(i_fault_clear),
	.i_supply_uv_detect(i_supply_uv_detect), .i_pump_uv_detect(i_pump_uv_detect),
	.o_high_side_overcurrent_threshold(o_high_side_overcurrent_threshold),
	.o_low_side_overcurrent_threshold(o_low_side_overcurrent_threshold),
	.o_offline_diagnostic_enable(o_offline_diagnostic_enable),
	.o_bridge1_pullup_source_enable(o_bridge1_pullup_source_enable),
	.o_bridge1_pulldown_source_enable(o_bridge1_pulldown_source_enable),
	.o_supply_undervoltage_response(o_supply_undervoltage_response),
	.o_supply_overvoltage_response(o_supply_overvoltage_response),
	.o_pump_undervoltage_response(o_pump_undervoltage_response),
	.o_amp_gain_select(o_amp_gain_select), .o_amp_gain_value(o_amp_gain_value),
	.o_supply_uv_fault(o_supply_uv_fault), .o_supply_ov_fault(o_supply_ov_fault),
	.o_supply_ov_warning(o_supply_ov_warning), .o_pump_uv_fault(o_pump_uv_fault));

// *** verification/gdmc_host_model.sv ***
// gdmc_host_model: host side of the register port, byte writes and reads
// assumes strobes sampled on the rising core clock edge
`timescale 1ns/1ns
module gdmc_host_model (
	input  wire logic       i_core_clk,
	input  wire logic [7:0] i_reg_rdata,
	input  wire logic       i_reg_rvalid,
	input  wire logic       i_reg_hit,
	output logic      [3:0] o_reg_addr,
	output logic      [7:0] o_reg_wdata,
	output logic            o_reg_wr,
	output logic            o_reg_rd
);
	initial begin
		o_reg_addr = 4'h0;
		o_reg_wdata = 8'h00;
		o_reg_wr = 1'b0;
		o_reg_rd = 1'b0;
	end

	task automatic write_reg(input logic [3:0] addr, input logic [7:0] data);
		@(posedge i_core_clk);
		o_reg_addr <= addr;
		o_reg_wdata <= data;
		o_reg_wr <= 1'b1;
		@(posedge i_core_clk);
		o_reg_wr <= 1'b0;
		o_reg_addr <= ~addr;
		o_reg_wdata <= ~data;
	endtask : write_reg

	task automatic read_reg(input logic [3:0] addr, output logic [7:0] data,
		output logic valid, output logic hit);
		@(posedge i_core_clk);
		o_reg_addr <= addr;
		o_reg_rd <= 1'b1;
		@(posedge i_core_clk);
		o_reg_rd <= 1'b0;
		o_reg_addr <= ~addr;
		#1;
		data = i_reg_rdata;
		valid = i_reg_rvalid;
		hit = i_reg_hit;
	endtask : read_reg
endmodule : gdmc_host_model

// *** verification/gdmc_regs_tb_top.sv ***
// gdmc_regs_tb_top: self-checking bench of the configuration bank
// assumes host model on the register port, bench drives the detectors
`timescale 1ns/1ns
`include "gdmc_defines.svh"
module gdmc_regs_tb_top;
	typedef struct packed {logic [3:0] a; logic [7:0] d; logic [7:0] e; logic h;} gdmc_row_type;
	logic clk, rst, wr, rd, rvalid, hit, clr, suv, sov, puv, v, h;
	logic [3:0] addr, hs_thr, ls_thr;
	logic [7:0] wdata, rdata, d;
	logic diag_en, rt_mon, pu_en, pd_en, suv_resp, sov_thr, puv_resp, puv_thr;
	logic sh_en, blk_src, blk_en, ref_div, suv_flt, sov_flt, sov_wrn, puv_flt;
	logic [1:0] sov_resp, sov_dg, gain_sel;
	logic [2:0] blk_time;
	logic [6:0] gain_val;
	int n_mismatch, total_checks;
	gdmc_row_type rows [5] = '{'{4'ha, 8'h5a, 8'h5a, 1'b1}, '{4'hb, 8'he3, 8'he3, 1'b1},
		'{4'hd, 8'hfe, 8'hfe, 1'b1}, '{4'h3, 8'h77, 8'h00, 1'b0}, '{4'hc, 8'h9b, 8'h9b, 1'b1}};

	gdmc_regs i_gdmc_regs (.i_core_clk(clk), .i_sys_rst(rst), .i_reg_addr(addr),
		.i_reg_wdata(wdata), .i_reg_wr(wr), .i_reg_rd(rd), .o_reg_rdata(rdata),
		.o_reg_rvalid(rvalid), .o_reg_hit(hit), .i_fault_clear(clr), .i_supply_uv_detect(suv),
		.i_supply_ov_detect(sov), .i_pump_uv_detect(puv),
		.o_high_side_overcurrent_threshold(hs_thr), .o_low_side_overcurrent_threshold(ls_thr),
		.o_offline_diagnostic_enable(diag_en), .o_vds_realtime_monitor(rt_mon),
		.o_bridge1_pullup_source_enable(pu_en), .o_bridge1_pulldown_source_enable(pd_en),
		.o_supply_undervoltage_response(suv_resp), .o_supply_overvoltage_response(sov_resp),
		.o_supply_overvoltage_deglitch(sov_dg), .o_supply_overvoltage_threshold(sov_thr),
		.o_pump_undervoltage_response(puv_resp), .o_pump_undervoltage_threshold(puv_thr),
		.o_amp_sample_hold_enable(sh_en), .o_amp_blanking_source_select(blk_src),
		.o_amp_blanking_time(blk_time), .o_amp_blanking_enable(blk_en),
		.o_amp_reference_divider(ref_div), .o_amp_gain_select(gain_sel),
		.o_amp_gain_value(gain_val), .o_supply_uv_fault(suv_flt),
		.o_supply_ov_fault(sov_flt), .o_supply_ov_warning(sov_wrn), .o_pump_uv_fault(puv_flt));
	gdmc_host_model i_gdmc_host_model (.i_core_clk(clk), .i_reg_rdata(rdata),
		.i_reg_rvalid(rvalid), .i_reg_hit(hit), .o_reg_addr(addr), .o_reg_wdata(wdata),
		.o_reg_wr(wr), .o_reg_rd(rd));

	always #5 clk = ~clk;

	task automatic check_val(input logic [7:0] seen, input logic [7:0] exp);
		total_checks++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check_val
	task automatic print_verdict;
		$display("checks %0d mismatches %0d", total_checks, n_mismatch);
		if (n_mismatch == 0 && total_checks > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : print_verdict
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
	endtask : tick
	task automatic look(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : look
	task automatic wr_reg(input logic [3:0] a, input logic [7:0] dat);
		i_gdmc_host_model.write_reg(a, dat);
		#1;
	endtask : wr_reg
	task automatic do_reset;
		rst <= 1'b1;
		tick(8);
		rst <= 1'b0;
	endtask : do_reset

	initial begin
		repeat (20000) @(posedge clk);
		n_mismatch++;
		print_verdict();
	end

	initial begin
		clk = 1'b0;
		rst = 1'b1;
		{clr, suv, sov, puv} = 4'h0;
		do_reset();
		foreach (rows[i]) begin
			wr_reg(rows[i].a, rows[i].d);
			i_gdmc_host_model.read_reg(rows[i].a, d, v, h);
			check_val(d, rows[i].e);
			check_val({6'h00, v, h}, {6'h00, 1'b1, rows[i].h});
		end
		check_val({hs_thr, ls_thr}, 8'h5a);
		check_val({5'h00, diag_en, pu_en, pd_en}, 8'h00);
		check_val({sh_en, blk_src, blk_time, ref_div, gain_sel}, 8'hfe);
		check_val({suv_resp, sov_resp, sov_dg, sov_thr, puv_resp, puv_thr}, 8'h9b);
		$display("test rows done");
		tick(1);
		do_reset();
		for (int i = 0; i < 4; i++) begin
			i_gdmc_host_model.read_reg(4'(4'ha + i), d, v, h);
			check_val(d, i == 0 ? `GDMC_RST_OC_THRESH : i == 1 ? `GDMC_RST_DIAG :
				i == 2 ? `GDMC_RST_SUPPLY_MON : `GDMC_RST_AMP);
		end
		check_val({1'b0, gain_val}, 8'h14);
		check_val({sov_dg, sov_thr, ref_div, pu_en, pd_en, hs_thr[3:2]}, 8'ha3);
		$display("test reset done");
		wr_reg(4'hb, 8'h0c);
		check_val({4'h0, diag_en, rt_mon, pu_en, pd_en}, 8'h00);
		wr_reg(4'hb, 8'h1c); // host sets enable with sources
		check_val({4'h0, diag_en, rt_mon, pu_en, pd_en}, 8'h0f);
		wr_reg(4'hb, 8'h14);
		check_val({4'h0, diag_en, rt_mon, pu_en, pd_en}, 8'h0d);
		for (int g = 0; g < 4; g++) begin
			wr_reg(4'hd, 8'(g * 9));
			check_val({1'b0, gain_val}, 8'(10 << g));
			check_val({7'h00, blk_en}, {7'h00, g != 0});
		end
		$display("test fields done");
		suv <= 1'b1;
		puv <= 1'b1;
		look(4);
		check_val({6'h00, suv_flt, puv_flt}, 8'h03);
		tick(1);
		clr <= 1'b1;
		tick(1);
		clr <= 1'b0;
		look(2);
		check_val({6'h00, suv_flt, puv_flt}, 8'h03);
		tick(1);
		{suv, puv} <= 2'b00;
		look(4);
		check_val({6'h00, suv_flt, puv_flt}, 8'h03);
		tick(1);
		clr <= 1'b1;
		tick(1);
		clr <= 1'b0;
		look(2);
		check_val({6'h00, suv_flt, puv_flt}, 8'h00);
		wr_reg(4'hc, 8'h96);
		{suv, puv} <= 2'b11;
		look(4);
		check_val({6'h00, suv_flt, puv_flt}, 8'h03);
		tick(1);
		{suv, puv} <= 2'b00;
		look(3);
		check_val({6'h00, suv_flt, puv_flt}, 8'h00);
		$display("test undervoltage done");
		for (int m = 0; m < 4; m++) begin
			wr_reg(4'hc, {1'b0, 2'(m), 2'(m), 3'b000});
			sov <= 1'b1;
			look((100 << m) - 50);
			check_val({6'h00, sov_flt, sov_wrn}, 8'h00);
			look(100);
			check_val({6'h00, sov_flt, sov_wrn}, {6'h00, m < 2, m == 2});
			tick(1);
			sov <= 1'b0;
			look(3);
			check_val({6'h00, sov_flt, sov_wrn}, {6'h00, m == 0, 1'b0});
			tick(1);
			clr <= 1'b1;
			tick(1);
			clr <= 1'b0;
			look(2);
			check_val({7'h00, sov_flt}, 8'h00);
		end
		$display("test overvoltage done");
		print_verdict();
	end
endmodule : gdmc_regs_tb_top
